// ---- hw/sau_cfg.svh ----
// Constants for the saturating arithmetic unit
// Functional notes
// - Signed word clamp: shift first, then clamp
// - Unsigned word clamp: shift, clamp to 0..2^n-1
// - Signed width 1..32, unsigned width 0..31
// - Pre-shift: arithmetic right 1..31 or left 0..31
// - Any clamp but lane add/sub sets sticky flag, else unchanged
// - Only status write or reset clears the sticky flag
// - Condition flags are never altered here
// - Dual-half signed clamp, width 1..16, per half
// - Dual-half unsigned clamp, width 0..15, per half
// - Signed halves land in their source positions
// - Unsigned halves land in their source positions
// - Signed add/sub clamps to lane width
// - Byte and half lanes clamp independently
// - Lane add/sub never touches the sticky flag
// - Signed add-sub exchange: top sum, bottom difference
// - Signed sub-add exchange: top difference, bottom sum
// - Double with clamp, add, clamp again
// - Double with clamp, subtract, clamp again
// - Either clamp step sets sticky flag
// - Unsigned add-sub exchange, clamp 0..65535
// - Unsigned sub-add exchange, clamp 0..65535
// - False condition suppresses write and flag
`ifndef SAU_CFG_SVH
`define SAU_CFG_SVH
`define SAU_DATA_W     32
`define SAU_HALF_W     16
`define SAU_BYTE_W     8
`define SAU_WIDTH_W    6
`define SAU_SHIFT_W    5
`define SAU_SP_IDX     4'hD
`define SAU_PC_IDX     4'hF
`define SAU_REG_IDX_W  4
`define SAU_LATENCY    1
`define SAU_FLAG_RST   1'h0
`endif

// ---- hw/sau_pkg.sv ----
// Types of the saturating arithmetic unit
package sau_pkg;
  typedef enum logic [4:0] {
    SAU_OP_SIGNED_WORD_CLAMP,
    SAU_OP_UNSIGNED_WORD_CLAMP,
    SAU_OP_SIGNED_DUAL_HALF_CLAMP,
    SAU_OP_UNSIGNED_DUAL_HALF_CLAMP,
    SAU_OP_CLAMPED_WORD_ADD,
    SAU_OP_CLAMPED_WORD_SUB,
    SAU_OP_CLAMPED_BYTE_LANE_ADD,
    SAU_OP_CLAMPED_BYTE_LANE_SUB,
    SAU_OP_CLAMPED_HALF_LANE_ADD,
    SAU_OP_CLAMPED_HALF_LANE_SUB,
    SAU_OP_SIGNED_ADD_SUB_EXCHANGE,
    SAU_OP_SIGNED_SUB_ADD_EXCHANGE,
    SAU_OP_DOUBLE_THEN_ADD_CLAMPED,
    SAU_OP_DOUBLE_THEN_SUB_CLAMPED,
    SAU_OP_UNSIGNED_ADD_SUB_EXCHANGE,
    SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE
  } sau_op_t;
  typedef enum logic {
    SAU_SHIFT_LOGICAL_LEFT,
    SAU_SHIFT_ARITH_RIGHT
  } sau_shift_t;
endpackage : sau_pkg

// ---- hw/sau_lane_clamp.sv ----
// One signed/unsigned add-subtract lane with clamping
module sau_lane_clamp #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] a_in,      // First operand lane
  input  wire logic [W-1:0] b_in,      // Second operand lane
  input  wire logic         sub_in,    // Subtract when high
  input  wire logic         uns_in,    // Unsigned range when high
  output logic      [W-1:0] res_out,   // Clamped lane result
  output logic              sat_out    // Lane was clamped
);
  initial begin
    if (W < 2) $error("lane width too small");
  end
  logic [W:0] sum;
  // Exact result with one extra bit, signed or unsigned extension
  always_comb begin
    if (uns_in) begin
      sum = sub_in ? ({1'b0, a_in} - {1'b0, b_in}) : ({1'b0, a_in} + {1'b0, b_in});
    end else begin
      sum = sub_in ? ({a_in[W-1], a_in} - {b_in[W-1], b_in}) : ({a_in[W-1], a_in} + {b_in[W-1], b_in});
    end
  end
  // Clamp on disagreement of the top two bits (signed) or carry/borrow (unsigned)
  always_comb begin
    res_out = sum[W-1:0];
    sat_out = 1'b0;
    if (uns_in) begin
      if (sum[W]) begin
        sat_out = 1'b1;
        res_out = sub_in ? '0 : '1;
      end
    end else if (sum[W] != sum[W-1]) begin
      sat_out = 1'b1;
      res_out = {sum[W], {(W-1){~sum[W]}}};
    end
  end
endmodule : sau_lane_clamp

// ---- hw/sau_word_clamp.sv ----
// Shift and clamp of a 32-bit word, or unshifted clamp of two halfwords, to width n
module sau_word_clamp #(
  parameter int DW = 32
) (
  input  wire logic [DW-1:0] src_in,     // Source operand
  input  wire logic [5:0]    width_in,   // Clamp width n
  input  wire logic          uns_in,     // Unsigned range
  input  wire logic          dual_in,    // Two independent halves
  input  wire logic          asr_in,     // Arithmetic right shift, else left
  input  wire logic [4:0]    shamt_in,   // Shift amount
  output logic      [DW-1:0] res_out,    // Clamped result
  output logic               sat_out     // A clamp occurred
);
  initial begin
    if (DW != 32) $error("word clamp serves 32 bits only");
  end
  // Clamp a signed value v to n bits; returns {sat, result}
  function automatic logic [DW:0] clamp(input logic signed [DW-1:0] v, input logic [5:0] n, input logic uns);
    logic signed [DW:0] hi;
    logic signed [DW:0] lo;
    logic signed [DW:0] x;
    x = {v[DW-1], v};
    if (uns) begin
      hi = (n == 6'h00) ? '0 : ((DW+1)'(1) << n) - (DW+1)'(1);
      lo = '0;
    end else begin
      hi = ((DW+1)'(1) << (n - 6'h01)) - (DW+1)'(1);
      lo = -((DW+1)'(1) << (n - 6'h01));
    end
    if (x > hi) clamp = {1'b1, hi[DW-1:0]};
    else if (x < lo) clamp = {1'b1, lo[DW-1:0]};
    else clamp = {1'b0, v};
  endfunction : clamp
  logic [DW-1:0] shifted;
  logic [DW:0]   w_r;
  logic [DW:0]   h1_r;
  logic [DW:0]   h0_r;
  // Pre-shift ahead of the clamp
  always_comb begin
    shifted = asr_in ? DW'($signed(src_in) >>> shamt_in) : (src_in << shamt_in);
  end
  assign w_r  = clamp(shifted, width_in, uns_in);
  assign h1_r = clamp({{16{src_in[31]}}, src_in[31:16]}, width_in, uns_in);
  assign h0_r = clamp({{16{src_in[15]}}, src_in[15:0]}, width_in, uns_in);
  // Halves return in the positions they came from
  always_comb begin
    if (dual_in) begin
      res_out = {h1_r[15:0], h0_r[15:0]};
      sat_out = h1_r[DW] | h0_r[DW];
    end else begin
      res_out = w_r[DW-1:0];
      sat_out = w_r[DW];
    end
  end
endmodule : sau_word_clamp

// ---- hw/sau_unit.sv ----
// Top of the saturating arithmetic unit
`include "sau_cfg.svh"
module sau_unit
  import sau_pkg::*;
#(
  parameter int DW = 32
) (
  input  wire logic           clk_in,          // Core clock
  input  wire logic           rstn_in,         // Asynchronous reset, active low
  input  wire logic           ce_in,           // Clock enable, freezes all state but the reset release
  input  wire logic           issue_in,        // Instruction issued this cycle
  input  wire sau_op_t        op_in,           // Operation code
  input  wire logic           cond_pass_in,    // Condition evaluated true
  input  wire logic [DW-1:0]  opa_in,          // First operand
  input  wire logic [DW-1:0]  opb_in,          // Second operand or source
  input  wire logic [5:0]     width_in,        // Clamp width n
  input  wire sau_shift_t     shift_kind_in,   // Pre-shift kind
  input  wire logic [4:0]     shamt_in,        // Pre-shift amount
  input  wire logic [3:0]     dest_idx_in,     // Destination register index
  input  wire logic           status_wr_in,    // Status write instruction
  input  wire logic           status_q_in,     // Flag value to write
  input  wire logic [3:0]     nzcv_in,         // Current condition flags
  output logic                wr_en_out,       // Destination write strobe
  output logic      [3:0]     wr_idx_out,      // Destination index
  output logic      [DW-1:0]  result_out,      // Result word
  output logic                sticky_sat_out,  // Sticky saturation flag
  output logic      [3:0]     nzcv_out         // Condition flags, passed unchanged
);
  initial begin
    if (DW != `SAU_DATA_W) $error("unit serves 32-bit data only");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_q;
  logic rstn_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rstn_q   <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rstn_q   <= rst_s1_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Operation decode
  logic word_op;
  logic uns_op;
  logic dual_op;
  logic lane_op;
  logic half_op;
  logic lane_sub;
  logic lane_uns;
  logic word_add_op;
  logic dbl_op;
  logic wide_sub;
  always_comb begin
    word_op  = op_in inside {SAU_OP_SIGNED_WORD_CLAMP, SAU_OP_UNSIGNED_WORD_CLAMP,
                              SAU_OP_SIGNED_DUAL_HALF_CLAMP, SAU_OP_UNSIGNED_DUAL_HALF_CLAMP};
    uns_op   = op_in inside {SAU_OP_UNSIGNED_WORD_CLAMP, SAU_OP_UNSIGNED_DUAL_HALF_CLAMP};
    dual_op  = op_in inside {SAU_OP_SIGNED_DUAL_HALF_CLAMP, SAU_OP_UNSIGNED_DUAL_HALF_CLAMP};
    lane_op  = op_in inside {SAU_OP_CLAMPED_BYTE_LANE_ADD, SAU_OP_CLAMPED_BYTE_LANE_SUB,
                              SAU_OP_CLAMPED_HALF_LANE_ADD, SAU_OP_CLAMPED_HALF_LANE_SUB};
    half_op  = op_in inside {SAU_OP_CLAMPED_HALF_LANE_ADD, SAU_OP_CLAMPED_HALF_LANE_SUB};
    lane_sub = op_in inside {SAU_OP_CLAMPED_BYTE_LANE_SUB, SAU_OP_CLAMPED_HALF_LANE_SUB};
    lane_uns = op_in inside {SAU_OP_UNSIGNED_ADD_SUB_EXCHANGE, SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE};
    word_add_op = op_in inside {SAU_OP_CLAMPED_WORD_ADD, SAU_OP_CLAMPED_WORD_SUB};
    dbl_op   = op_in inside {SAU_OP_DOUBLE_THEN_ADD_CLAMPED, SAU_OP_DOUBLE_THEN_SUB_CLAMPED};
    wide_sub = op_in inside {SAU_OP_CLAMPED_WORD_SUB, SAU_OP_DOUBLE_THEN_SUB_CLAMPED};
  end
  ////////////////////////////////////////////////////////////////////////////
  // Word and dual-half clamp
  logic [DW-1:0] wc_res;
  logic          wc_sat;
  sau_word_clamp #(.DW(DW)) u_word (
    .src_in   (opb_in),
    .width_in (width_in),
    .uns_in   (uns_op),
    .dual_in  (dual_op),
    .asr_in   (shift_kind_in == SAU_SHIFT_ARITH_RIGHT),
    .shamt_in (shamt_in),
    .res_out  (wc_res),
    .sat_out  (wc_sat)
  );
  ////////////////////////////////////////////////////////////////////////////
  // 32-bit signed add and subtract, plain or after a clamped doubling
  function automatic logic [DW:0] sat_addsub(input logic [DW-1:0] a, input logic [DW-1:0] b, input logic sub);
    logic [DW:0] s;
    s = sub ? ({a[DW-1], a} - {b[DW-1], b}) : ({a[DW-1], a} + {b[DW-1], b});
    if (s[DW] != s[DW-1]) sat_addsub = {1'b1, s[DW], {(DW-1){~s[DW]}}};
    else sat_addsub = {1'b0, s[DW-1:0]};
  endfunction : sat_addsub
  logic [DW:0] dbl_r;
  logic [DW:0] wide_r;
  assign dbl_r  = sat_addsub(opb_in, opb_in, 1'b0);
  assign wide_r = sat_addsub(opa_in, dbl_op ? dbl_r[DW-1:0] : opb_in, wide_sub);
  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes, four independent adders
  logic [DW-1:0] byte_res;
  for (genvar g = 0; g < 4; g++) begin : g_byte
    sau_lane_clamp #(.W(`SAU_BYTE_W)) u_lane (
      .a_in    (opa_in[g*8 +: 8]),
      .b_in    (opb_in[g*8 +: 8]),
      .sub_in  (lane_sub),
      .uns_in  (1'b0),
      .res_out (byte_res[g*8 +: 8]),
      .sat_out ()
    );
  end
  ////////////////////////////////////////////////////////////////////////////
  // Halfword lanes; exchange forms cross the halves of the second operand
  logic        xch;
  logic        top_sub;
  logic        bot_sub;
  logic [15:0] hb_top;
  logic [15:0] hb_bot;
  logic [15:0] hr_top;
  logic [15:0] hr_bot;
  logic        hs_top;
  logic        hs_bot;
  always_comb begin
    xch     = !half_op;
    top_sub = half_op ? lane_sub : (op_in inside {SAU_OP_SIGNED_SUB_ADD_EXCHANGE,
                                                  SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE});
    bot_sub = half_op ? lane_sub : !top_sub;
    hb_top  = xch ? opb_in[15:0] : opb_in[31:16];
    hb_bot  = xch ? opb_in[31:16] : opb_in[15:0];
  end
  sau_lane_clamp #(.W(`SAU_HALF_W)) u_htop (
    .a_in    (opa_in[31:16]),
    .b_in    (hb_top),
    .sub_in  (top_sub),
    .uns_in  (lane_uns),
    .res_out (hr_top),
    .sat_out (hs_top)
  );
  sau_lane_clamp #(.W(`SAU_HALF_W)) u_hbot (
    .a_in    (opa_in[15:0]),
    .b_in    (hb_bot),
    .sub_in  (bot_sub),
    .uns_in  (lane_uns),
    .res_out (hr_bot),
    .sat_out (hs_bot)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Result and saturation select
  logic [DW-1:0] res_d;
  logic          sat_d;
  always_comb begin
    if (word_op) begin
      res_d = wc_res;
      sat_d = wc_sat;
    end else if (word_add_op || dbl_op) begin
      res_d = wide_r[DW-1:0];
      sat_d = wide_r[DW] | (dbl_op & dbl_r[DW]);
    end else if (lane_op && !half_op) begin
      res_d = byte_res;
      sat_d = 1'b0;
    end else if (half_op) begin
      res_d = {hr_top, hr_bot};
      sat_d = 1'b0;
    end else begin
      res_d = {hr_top, hr_bot};
      sat_d = hs_top | hs_bot;
    end
  end
  logic fire;
  assign fire = issue_in && cond_pass_in;
  ////////////////////////////////////////////////////////////////////////////
  // Result register
  always_ff @(posedge clk_in or negedge rstn_q) begin
    if (!rstn_q) begin
      wr_en_out  <= 1'b0;
      wr_idx_out <= 4'h0;
      result_out <= '0;
    end else if (ce_in) begin
      wr_en_out <= fire;
      if (fire) begin
        wr_idx_out <= dest_idx_in;
        result_out <= res_d;
      end
    end
  end
  // Sticky flag: set wins over a simultaneous clear
  always_ff @(posedge clk_in or negedge rstn_q) begin
    if (!rstn_q) begin
      sticky_sat_out <= `SAU_FLAG_RST;
    end else if (ce_in) begin
      if (fire && sat_d) sticky_sat_out <= 1'b1;
      else if (status_wr_in) sticky_sat_out <= status_q_in;
    end
  end
  // Condition flags pass through untouched
  always_ff @(posedge clk_in or negedge rstn_q) begin
    if (!rstn_q) begin
      nzcv_out <= 4'h0;
    end else if (ce_in) begin
      nzcv_out <= nzcv_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_no_clear;
    @(posedge clk_in) disable iff (!rstn_q)
      (ce_in && !status_wr_in && sticky_sat_out) |=> sticky_sat_out;
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("sticky flag cleared");
  property p_set;
    @(posedge clk_in) disable iff (!rstn_q)
      (ce_in && fire && sat_d) |=> sticky_sat_out;
  endproperty
  a_set: assert property (p_set) else $error("sticky flag not set");
  property p_cond;
    @(posedge clk_in) disable iff (!rstn_q)
      (ce_in && !fire && !status_wr_in) |=> (!wr_en_out && $stable(sticky_sat_out));
  endproperty
  a_cond: assert property (p_cond) else $error("write on false condition");
  property p_lane;
    @(posedge clk_in) disable iff (!rstn_q)
      (ce_in && fire && lane_op && !status_wr_in && !sticky_sat_out) |=> !sticky_sat_out;
  endproperty
  a_lane: assert property (p_lane) else $error("lane op set flag");
  property p_flags;
    @(posedge clk_in) disable iff (!rstn_q)
      ce_in |=> (nzcv_out == $past(nzcv_in));
  endproperty
  a_flags: assert property (p_flags) else $error("condition flags changed");
  property p_result;
    @(posedge clk_in) disable iff (!rstn_q)
      (ce_in && fire) |=> (wr_en_out && result_out == $past(res_d));
  endproperty
  a_result: assert property (p_result) else $error("result not written");
  property p_unsigned_word_clamp_range;
    @(posedge clk_in) disable iff (!rstn_q)
      (ce_in && fire && op_in == SAU_OP_UNSIGNED_WORD_CLAMP && width_in < 6'd31)
        |=> (result_out >> $past(width_in)) == '0;
  endproperty
  a_unsigned_word_clamp_range: assert property (p_unsigned_word_clamp_range) else $error("unsigned clamp out of range");
  property p_dbl;
    @(posedge clk_in) disable iff (!rstn_q)
      (ce_in && fire && dbl_op && dbl_r[DW]) |=> sticky_sat_out;
  endproperty
  a_dbl: assert property (p_dbl) else $error("doubling clamp missed");
  c_word_sat: cover property (@(posedge clk_in) fire && word_op && sat_d);
  c_dbl_sat:  cover property (@(posedge clk_in) fire && dbl_op && dbl_r[DW]);
  c_byte:     cover property (@(posedge clk_in) fire && lane_op && !half_op);
  c_uxch:     cover property (@(posedge clk_in) fire && lane_uns && sat_d);
endmodule : sau_unit

// ---- testbench/sau_issue_model.sv ----
// Pipeline model that issues decoded operations to the saturating unit
`include "sau_cfg.svh"
module sau_issue_model
  import sau_pkg::*;
(
  input  wire logic        clk_in,     // Core clock
  output logic             ce_out,     // Clock enable
  output logic             issue_out,  // Issue strobe
  output sau_op_t          op_out,     // Operation code
  output logic             cond_out,   // Condition passed
  output logic      [31:0] opa_out,    // First operand
  output logic      [31:0] opb_out,    // Second operand
  output logic      [5:0]  width_out,  // Clamp width
  output sau_shift_t       shk_out,    // Shift kind
  output logic      [4:0]  shamt_out,  // Shift amount
  output logic      [3:0]  dest_out,   // Destination index
  output logic             swr_out,    // Status write strobe
  output logic             sq_out,     // Status value
  output logic      [3:0]  nzcv_out    // Condition flags
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////
  // Idle values at time zero
  initial begin
    {ce_out, issue_out, cond_out, swr_out, sq_out} = 5'h10;
    op_out = SAU_OP_CLAMPED_WORD_ADD;
    {opa_out, opb_out, width_out, shamt_out, dest_out, nzcv_out} = '0;
    shk_out = SAU_SHIFT_LOGICAL_LEFT;
  end
  ////////////////////////////////////////////////////////////////
  // One issue cycle; operands scrambled once the unit has taken them
  task automatic issue(input sau_op_t o, input logic [31:0] a, b, input logic [5:0] n, input logic arith_right_shift,
                       input logic [4:0] s, input logic [3:0] d, input logic cnd, ce);
    @(posedge clk_in);
    #1;
    op_out = o;
    opa_out = a;
    opb_out = b;
    width_out = n;                                         // Caller keeps n in range
    shk_out = arith_right_shift ? SAU_SHIFT_ARITH_RIGHT : SAU_SHIFT_LOGICAL_LEFT;
    shamt_out = (arith_right_shift && s == 5'h0) ? 5'h1 : s;
    dest_out = (d == `SAU_SP_IDX || d == `SAU_PC_IDX) ? 4'h0 : d;
    nzcv_out = a[3:0] ^ 4'hA;
    cond_out = cnd;
    ce_out = ce;
    issue_out = 1'h1;
    @(posedge clk_in);
    #1;
    issue_out = 1'h0;
    ce_out = 1'h1;
    opa_out = ~opa_out;
    opb_out = ~opb_out;
  endtask : issue
  // One status write cycle
  task automatic swr(input logic v);
    @(posedge clk_in);
    #1;
    swr_out = 1'h1;
    sq_out = v;
    @(posedge clk_in);
    #1;
    swr_out = 1'h0;
    sq_out = ~v;
  endtask : swr
endmodule : sau_issue_model

// ---- testbench/tb_top.sv ----
// Self-checking testbench of the saturating arithmetic unit
module tb_top
  import sau_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic ce, iss, cnd, swr, sq, wr_en, st, exp_q;
  bit sat_f;
  sau_op_t op;
  sau_shift_t shk;
  logic [31:0] opa, opb, res;
  logic [5:0] wd;
  logic [4:0] sa;
  logic [3:0] dst, nz, wi, nzo;
  int error_cnt = 0;
  int n_tests = 0;
  sau_op_t xo[4] = '{SAU_OP_SIGNED_ADD_SUB_EXCHANGE, SAU_OP_SIGNED_SUB_ADD_EXCHANGE,
                     SAU_OP_UNSIGNED_ADD_SUB_EXCHANGE, SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE};
  // Clock
  always #2 clk_in = ~clk_in;
  sau_issue_model pm (.clk_in(clk_in), .ce_out(ce), .issue_out(iss), .op_out(op), .cond_out(cnd),
    .opa_out(opa), .opb_out(opb), .width_out(wd), .shk_out(shk), .shamt_out(sa), .dest_out(dst),
    .swr_out(swr), .sq_out(sq), .nzcv_out(nz));
  sau_unit #(.DW(32)) uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce), .issue_in(iss), .op_in(op),
    .cond_pass_in(cnd), .opa_in(opa), .opb_in(opb), .width_in(wd), .shift_kind_in(shk), .shamt_in(sa),
    .dest_idx_in(dst), .status_wr_in(swr), .status_q_in(sq), .nzcv_in(nz), .wr_en_out(wr_en),
    .wr_idx_out(wi), .result_out(res), .sticky_sat_out(st), .nzcv_out(nzo));
  ////////////////////////////////////////////////////////////////
  // Reference arithmetic, exact in 64 bits
  function automatic longint cl(longint v, longint lo, longint hi);
    if (v < lo || v > hi) sat_f = 1'h1;
    return v < lo ? lo : (v > hi ? hi : v);
  endfunction : cl
  function automatic longint cs(longint v, int n);
    return cl(v, -(longint'(1) << (n - 1)), (longint'(1) << (n - 1)) - 1);
  endfunction : cs
  function automatic longint cu(longint v, int n);
    return cl(v, 0, (longint'(1) << n) - 1);
  endfunction : cu
  function automatic longint h(logic [31:0] x, int i, bit u);
    return u ? longint'(x[i*16+:16]) : longint'($signed(x[i*16+:16]));
  endfunction : h
  function automatic logic [31:0] ref_op(sau_op_t o, logic [31:0] a, b, int n, logic arith_right_shift, int s);
    logic [31:0] r, t;
    logic [4:0] ob;
    longint m;
    ob = o;
    sat_f = 1'h0;
    r = '0;
    m = ob[0] ? -1 : 1;
    if (arith_right_shift) t = $signed(b) >>> s;
    else t = b << s;
    case (o)
      SAU_OP_SIGNED_WORD_CLAMP: r = 32'(cs(longint'($signed(t)), n));
      SAU_OP_UNSIGNED_WORD_CLAMP: r = 32'(cu(longint'($signed(t)), n));
      SAU_OP_SIGNED_DUAL_HALF_CLAMP, SAU_OP_UNSIGNED_DUAL_HALF_CLAMP:
        for (int i = 0; i < 2; i++) r[i*16+:16] = 16'(ob[0] ? cu(h(b, i, 0), n) : cs(h(b, i, 0), n));
      SAU_OP_CLAMPED_WORD_ADD, SAU_OP_CLAMPED_WORD_SUB:
        r = 32'(cs(longint'($signed(a)) + m * longint'($signed(b)), 32));
      SAU_OP_CLAMPED_BYTE_LANE_ADD, SAU_OP_CLAMPED_BYTE_LANE_SUB:
        for (int i = 0; i < 4; i++) r[i*8+:8] = 8'(cs(longint'($signed(a[i*8+:8])) + m * longint'($signed(b[i*8+:8])), 8));
      SAU_OP_CLAMPED_HALF_LANE_ADD, SAU_OP_CLAMPED_HALF_LANE_SUB:
        for (int i = 0; i < 2; i++) r[i*16+:16] = 16'(cs(h(a, i, 0) + m * h(b, i, 0), 16));
      SAU_OP_SIGNED_ADD_SUB_EXCHANGE: r = {16'(cs(h(a, 1, 0) + h(b, 0, 0), 16)), 16'(cs(h(a, 0, 0) - h(b, 1, 0), 16))};
      SAU_OP_SIGNED_SUB_ADD_EXCHANGE: r = {16'(cs(h(a, 1, 0) - h(b, 0, 0), 16)), 16'(cs(h(a, 0, 0) + h(b, 1, 0), 16))};
      SAU_OP_UNSIGNED_ADD_SUB_EXCHANGE: r = {16'(cu(h(a, 1, 1) + h(b, 0, 1), 16)), 16'(cu(h(a, 0, 1) - h(b, 1, 1), 16))};
      SAU_OP_UNSIGNED_SUB_ADD_EXCHANGE: r = {16'(cu(h(a, 1, 1) - h(b, 0, 1), 16)), 16'(cu(h(a, 0, 1) + h(b, 1, 1), 16))};
      default: r = 32'(cs(longint'($signed(a)) + m * cs(2 * longint'($signed(b)), 32), 32));
    endcase
    if (ob inside {[6:9]}) sat_f = 1'h0;
    return r;
  endfunction : ref_op
  ////////////////////////////////////////////////////////////////
  // Shared comparison and operation tasks
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_op(input sau_op_t o, input logic [31:0] a, b, input int n = 0, input logic arith_right_shift = 0,
                       input int s = 0);
    logic [31:0] e;
    e = ref_op(o, a, b, n, arith_right_shift, s);
    exp_q = exp_q | sat_f;
    pm.issue(o, a, b, 6'(n), arith_right_shift, 5'(s), 4'h3, 1'h1, 1'h1);
    chk("wr_en", 1, wr_en);
    chk("result", e, res);
    chk("wr_idx", 3, wi);
    chk("sticky", exp_q, st);
    chk("nzcv", a[3:0] ^ 4'hA, nzo);
  endtask : do_op
  task automatic stw(input logic v);
    pm.swr(v);
    exp_q = v;
    chk("sticky", v, st);
  endtask : stw
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_word;
    do_op(SAU_OP_SIGNED_WORD_CLAMP, 0, 32'h8000_0000, 32, 1, 31);
    do_op(SAU_OP_UNSIGNED_WORD_CLAMP, 0, 32'h0000_0100, 31, 0, 0);
    do_op(SAU_OP_SIGNED_WORD_CLAMP, 0, 32'h0000_1234, 16, 0, 4);
    do_op(SAU_OP_SIGNED_WORD_CLAMP, 0, 32'hFFFF_F000, 8, 1, 4);
    do_op(SAU_OP_SIGNED_WORD_CLAMP, 0, 32'h0000_0002, 1, 0, 0);
    do_op(SAU_OP_UNSIGNED_WORD_CLAMP, 0, 32'hFFFF_FF00, 7, 0, 0);
    do_op(SAU_OP_UNSIGNED_WORD_CLAMP, 0, 32'h0000_0005, 0, 0, 0);
    $display("word clamp test done");
  endtask : t_word
  task automatic t_dual;
    do_op(SAU_OP_SIGNED_DUAL_HALF_CLAMP, 0, 32'h7FFF_8000, 9);
    do_op(SAU_OP_SIGNED_DUAL_HALF_CLAMP, 0, 32'h0003_FFFC, 1);
    do_op(SAU_OP_UNSIGNED_DUAL_HALF_CLAMP, 0, 32'h8000_7FFF, 15);
    do_op(SAU_OP_UNSIGNED_DUAL_HALF_CLAMP, 0, 32'h0040_0001, 0);
    $display("dual half test done");
  endtask : t_dual
  task automatic t_addsub;
    do_op(SAU_OP_CLAMPED_WORD_ADD, 32'h7FFF_FFFF, 32'h0000_0001);
    do_op(SAU_OP_CLAMPED_WORD_SUB, 32'h8000_0000, 32'h0000_0001);
    do_op(SAU_OP_CLAMPED_WORD_SUB, 32'h0000_0010, 32'h0000_0020);
    stw(1'h0);
    for (int i = 6; i < 10; i++) begin
      do_op(sau_op_t'(i), 32'h7F80_0180, 32'h0181_7F81);
    end
    $display("add sub test done");
  endtask : t_addsub
  task automatic t_exch;
    for (int i = 0; i < 4; i++) begin
      do_op(xo[i], 32'h7FFF_8001, 32'h8002_7FFE);
      do_op(xo[i], 32'hFFFF_0001, 32'h0002_0003);
    end
    $display("exchange test done");
  endtask : t_exch
  task automatic t_dbl;
    stw(1'h0);
    do_op(SAU_OP_DOUBLE_THEN_ADD_CLAMPED, 32'h8000_0000, 32'h4000_0000);
    stw(1'h0);
    do_op(SAU_OP_DOUBLE_THEN_SUB_CLAMPED, 32'h8000_0000, 32'h0000_0001);
    do_op(SAU_OP_DOUBLE_THEN_SUB_CLAMPED, 32'h0000_0100, 32'hFFFF_FFF0);
    $display("double test done");
  endtask : t_dbl
  task automatic t_refuse;
    logic [31:0] keep;
    stw(1'h0);
    keep = res;
    pm.issue(SAU_OP_CLAMPED_WORD_ADD, 32'h7FFF_FFFF, 32'h1, 0, 0, 0, 4'h5, 1'h0, 1'h1);
    chk("wr_en", 0, wr_en);
    chk("sticky", 0, st);
    chk("result", keep, res);
    pm.issue(SAU_OP_CLAMPED_WORD_ADD, 32'h7FFF_FFFF, 32'h1, 0, 0, 0, 4'h5, 1'h1, 1'h0);
    chk("wr_en", 0, wr_en);
    chk("sticky", 0, st);
    stw(1'h1);
    do_op(SAU_OP_CLAMPED_WORD_ADD, 32'h0000_0001, 32'h0000_0001);
    $display("refusal test done");
  endtask : t_refuse
  ////////////////////////////////////////////////////////////////
  // Verdict
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // Watchdog against a hang
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  // Main sequence
  initial begin
    exp_q = 1'h0;
    repeat (2) @(posedge clk_in);
    #1;
    rstn_in = 1'h1;
    repeat (4) @(posedge clk_in);
    t_word();
    t_dual();
    t_addsub();
    t_exch();
    t_dbl();
    t_refuse();
    end_sim();
  end
endmodule : tb_top
